//--- mtc_timer.sv
// mtc_timer: 16-bit modulo timer with prescaler and two channels.
// assumes one AHB-Lite master, word transfers, clk_sys as HCLK.
// Operation
// - each channel pin capture or compare
// - channels 0/1 buffered compare and PWM
// - wrap flag sets on reaching period
// - flag clears by read-set then write zero
// - overflow between read and write keeps flag
// - writing one ignored; reset clears flag
// - irq when flag and enable; enable resets
// - halt bit freezes counter; reset halts
// - halt blocks input captures
// - counter reset clears counter and prescaler
// - counter reset bit self-clears, reads zero
// - halt plus reset leaves zero halted
// - divider select: seven taps or pin
// - high byte read latches low byte
// - latch held until low byte read
// - latch persists through debug break
// - resets clear counter byte registers
// - restart from zero next tick
// - period high write suppresses flag
// - period resets to all ones
// - channel flag on edge or match
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module mtc_timer (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_count_clock_pin,
    input  wire logic        debug_break,
    input  wire logic        chan0_pin_in,
    output logic             chan0_pin_out,
    output logic             chan0_pin_oe,
    input  wire logic        chan1_pin_in,
    output logic             chan1_pin_out,
    output logic             chan1_pin_oe,
    output logic             wrap_irq,
    output logic             chan0_irq,
    output logic             chan1_irq
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic div_tick(input logic [5:0] p,
                                      input logic [2:0] sel);
        logic [5:0] m;
        m = 6'((7'h01 << sel) - 7'h01);
        return (p & m) == m;
    endfunction

    function automatic logic [7:0] ch_idx(input int unsigned ch,
                                          input logic [7:0] off);
        return (ch == 0) ? (mtc_pkg::IDX_CH0_SC + off)
                         : (mtc_pkg::IDX_CH1_SC + off);
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic        acc_q;
    logic [7:0]  idx_q;
    logic        take;
    logic        a_map;
    logic [7:0]  a_idx;
    logic [7:0]  wd;
    logic [7:0]  rd_byte;
    logic [5:0]  presc_q;
    logic [2:0]  ext_s_q;
    logic        tick;
    logic        run;
    logic        trst_w;
    logic        wrap_evt;
    logic        ovf_evt;
    logic [15:0] cnt_q;
    logic [15:0] cnt_next;
    logic [15:0] period_q;
    logic        per_lock_q;
    logic        flag_q;
    logic        arm_q;
    logic        irq_en_q;
    logic        halt_q;
    logic [2:0]  sel_q;
    logic        lo_latched_q;
    logic [7:0]  lo_buf_q;
    logic [7:0]  ch_sc_q   [2];
    logic [15:0] ch_val_q  [2];
    logic [1:0]  ch_wlock_q;
    logic [1:0]  ch_rlock_q;
    logic [1:0]  ch_arm_q;
    logic [1:0]  ch_out_q;
    logic [1:0]  ch_oe_q;
    logic [1:0]  ch_irq_q;
    logic [2:0]  pin_s_q   [2];
    logic        buf_sel_q;
    logic        last_wr_q;
    logic        buffered;
    logic [1:0]  cap_mode;
    logic [1:0]  cmp_mode;
    logic [1:0]  cap_evt;
    logic [1:0]  cmp_evt;
    logic [1:0]  pin_in;
    logic [15:0] cmp_val   [2];

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    assign take   = hsel && hready && htrans[1] && hsize == mtc_pkg::HSIZE_WORD;
    assign a_map  = haddr[31:10] == mtc_pkg::HADDR_HI_0 && haddr[1:0] == 2'h0;
    assign a_idx  = a_map ? haddr[9:2] : mtc_pkg::IDX_NONE;
    assign wd     = hwdata[7:0];
    assign pin_in = {chan1_pin_in, chan0_pin_in};

    function automatic logic rd_at(input logic [7:0] idx);
        return take && !hwrite && a_idx == idx;
    endfunction

    function automatic logic wr_at(input logic [7:0] idx);
        return acc_q && idx_q == idx;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acc_q <= 1'b0;
            idx_q <= mtc_pkg::IDX_NONE;
        end else begin
            acc_q <= take && hwrite;
            if (take) begin
                idx_q <= a_idx;
            end
        end
    end

    // side effects of reads happen at the address phase, so the data
    // captured into hrdata and the low-byte latch are coherent
    always_comb begin
        rd_byte = 8'h00;
        case (a_idx)
            mtc_pkg::IDX_STATUS: rd_byte = {flag_q, irq_en_q, halt_q, 2'b00, sel_q};
            mtc_pkg::IDX_CNT_HI: rd_byte = cnt_q[15:8];
            mtc_pkg::IDX_CNT_LO: rd_byte = lo_latched_q ? lo_buf_q : cnt_q[7:0];
            mtc_pkg::IDX_PER_HI: rd_byte = period_q[15:8];
            mtc_pkg::IDX_PER_LO: rd_byte = period_q[7:0];
            ch_idx(0, 8'h00):    rd_byte = ch_sc_q[0];
            ch_idx(0, mtc_pkg::CH_HI_OFF): rd_byte = ch_val_q[0][15:8];
            ch_idx(0, mtc_pkg::CH_LO_OFF): rd_byte = ch_val_q[0][7:0];
            ch_idx(1, 8'h00):    rd_byte = ch_sc_q[1];
            ch_idx(1, mtc_pkg::CH_HI_OFF): rd_byte = ch_val_q[1][15:8];
            ch_idx(1, mtc_pkg::CH_LO_OFF): rd_byte = ch_val_q[1][7:0];
            default:             rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // clock source and prescaler
    // ----------------------------------------------------------------
    assign trst_w = wr_at(mtc_pkg::IDX_STATUS) && wd[mtc_pkg::SC_RST];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ext_s_q <= 3'h0;
        end else begin
            ext_s_q <= {ext_s_q[1:0], ext_count_clock_pin};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || trst_w) begin
            presc_q <= mtc_pkg::PRESC_RST;
        end else begin
            presc_q <= presc_q + 6'h01;
        end
    end

    // external pin counts on its synchronised rising edge; its rate
    // must stay below half of clk_sys
    assign tick = (sel_q == mtc_pkg::SEL_EXT) ? (ext_s_q[1] && !ext_s_q[2])
                                              : div_tick(presc_q, sel_q);

    // a debug break freezes counting as well as the halt bit
    assign run      = tick && !halt_q && !debug_break && !trst_w;
    assign cnt_next = (cnt_q == period_q) ? mtc_pkg::CNT_RST : cnt_q + 16'h0001;
    assign wrap_evt = run && cnt_q == period_q;
    assign ovf_evt  = run && cnt_next == period_q && !per_lock_q;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || trst_w) begin
            cnt_q <= mtc_pkg::CNT_RST;
        end else if (run) begin
            cnt_q <= cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // status/control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_en_q <= 1'b0;
            halt_q   <= 1'b1;
            sel_q    <= mtc_pkg::SEL_RST;
        end else if (wr_at(mtc_pkg::IDX_STATUS)) begin
            irq_en_q <= wd[mtc_pkg::SC_IE];
            halt_q   <= wd[mtc_pkg::SC_HALT];
            sel_q    <= wd[2:0];
        end
    end

    // a new overflow disarms the pending clear, so a stale write of
    // zero cannot drop it; the set also wins in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (ovf_evt) begin
            flag_q <= 1'b1;
        end else if (wr_at(mtc_pkg::IDX_STATUS) && !wd[mtc_pkg::SC_FLAG] && arm_q) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            arm_q <= 1'b0;
        end else if (ovf_evt) begin
            arm_q <= 1'b0;
        end else if (rd_at(mtc_pkg::IDX_STATUS) && flag_q) begin
            arm_q <= 1'b1;
        end else if (wr_at(mtc_pkg::IDX_STATUS)) begin
            arm_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrap_irq <= 1'b0;
        end else begin
            wrap_irq <= flag_q && irq_en_q;
        end
    end

    // ----------------------------------------------------------------
    // period registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            period_q   <= mtc_pkg::PERIOD_RST;
            per_lock_q <= 1'b0;
        end else if (wr_at(mtc_pkg::IDX_PER_HI)) begin
            period_q[15:8] <= wd;
            per_lock_q     <= 1'b1;
        end else if (wr_at(mtc_pkg::IDX_PER_LO)) begin
            period_q[7:0] <= wd;
            per_lock_q    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // coherent counter read latch
    // ----------------------------------------------------------------
    // the latch ignores debug_break on purpose: it stays until the low
    // byte is read
    always_ff @(posedge clk_sys) begin
        if (srst || trst_w) begin
            lo_latched_q <= 1'b0;
            lo_buf_q     <= 8'h00;
        end else if (rd_at(mtc_pkg::IDX_CNT_LO)) begin
            lo_latched_q <= 1'b0;
        end else if (rd_at(mtc_pkg::IDX_CNT_HI) && !lo_latched_q) begin
            lo_latched_q <= 1'b1;
            lo_buf_q     <= cnt_q[7:0];
        end
    end

    // ----------------------------------------------------------------
    // channel events
    // ----------------------------------------------------------------
    assign buffered = ch_sc_q[0][mtc_pkg::CH_MSB];

    always_comb begin
        mtc_pkg::mtc_els_e els;
        logic rise;
        logic fall;
        logic hit;
        els      = mtc_pkg::MTC_ELS_OFF;
        rise     = 1'b0;
        fall     = 1'b0;
        hit      = 1'b0;
        cap_mode = 2'b00;
        cmp_mode = 2'b00;
        cap_evt  = 2'b00;
        cmp_evt  = 2'b00;
        cmp_val[0] = buffered ? ch_val_q[buf_sel_q] : ch_val_q[0];
        cmp_val[1] = ch_val_q[1];
        for (int i = 0; i < 2; i++) begin
            els  = mtc_pkg::mtc_els_e'(ch_sc_q[i][3:2]);
            rise = pin_s_q[i][1] && !pin_s_q[i][2];
            fall = !pin_s_q[i][1] && pin_s_q[i][2];
            case (els)
                mtc_pkg::MTC_ELS_RISE: hit = rise;
                mtc_pkg::MTC_ELS_FALL: hit = fall;
                mtc_pkg::MTC_ELS_BOTH: hit = rise || fall;
                default:               hit = 1'b0;
            endcase
            // channel 1 is handed to port logic while buffered
            if (!(i == 1 && buffered)) begin
                cmp_mode[i] = ch_sc_q[i][mtc_pkg::CH_MSB] || ch_sc_q[i][mtc_pkg::CH_MSA];
                cap_mode[i] = !cmp_mode[i] && els != mtc_pkg::MTC_ELS_OFF;
            end
            cap_evt[i] = cap_mode[i] && hit && !halt_q && !debug_break && !ch_rlock_q[i];
            cmp_evt[i] = cmp_mode[i] && run && cnt_next == cmp_val[i] && !ch_wlock_q[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (srst) begin
                pin_s_q[i] <= 3'h0;
            end else begin
                pin_s_q[i] <= {pin_s_q[i][1:0], pin_in[i]};
            end
        end
    end

    // ----------------------------------------------------------------
    // channel registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (srst) begin
                ch_sc_q[i]  <= mtc_pkg::CH_SC_RST;
                ch_arm_q[i] <= 1'b0;
            end else begin
                if (wr_at(ch_idx(i, 8'h00))) begin
                    ch_sc_q[i][6:0] <= wd[6:0];
                    if (i == 1) begin
                        ch_sc_q[i][mtc_pkg::CH_MSB] <= 1'b0;
                    end
                end
                if (cap_evt[i] || cmp_evt[i]) begin
                    ch_sc_q[i][mtc_pkg::CH_FLAG] <= 1'b1;
                    ch_arm_q[i] <= 1'b0;
                end else if (wr_at(ch_idx(i, 8'h00))) begin
                    if (!wd[mtc_pkg::CH_FLAG] && ch_arm_q[i]) begin
                        ch_sc_q[i][mtc_pkg::CH_FLAG] <= 1'b0;
                    end
                    ch_arm_q[i] <= 1'b0;
                end else if (rd_at(ch_idx(i, 8'h00)) && ch_sc_q[i][mtc_pkg::CH_FLAG]) begin
                    ch_arm_q[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (srst) begin
                ch_val_q[i]   <= mtc_pkg::CNT_RST;
                ch_wlock_q[i] <= 1'b0;
                ch_rlock_q[i] <= 1'b0;
            end else begin
                if (cap_evt[i]) begin
                    ch_val_q[i] <= cnt_q;
                end else if (wr_at(ch_idx(i, mtc_pkg::CH_HI_OFF))) begin
                    ch_val_q[i][15:8] <= wd;
                end else if (wr_at(ch_idx(i, mtc_pkg::CH_LO_OFF))) begin
                    ch_val_q[i][7:0] <= wd;
                end
                // a half-written compare value must not match
                if (wr_at(ch_idx(i, mtc_pkg::CH_HI_OFF))) begin
                    ch_wlock_q[i] <= 1'b1;
                end else if (wr_at(ch_idx(i, mtc_pkg::CH_LO_OFF))) begin
                    ch_wlock_q[i] <= 1'b0;
                end
                if (rd_at(ch_idx(i, mtc_pkg::CH_HI_OFF)) && cap_mode[i]) begin
                    ch_rlock_q[i] <= 1'b1;
                end else if (rd_at(ch_idx(i, mtc_pkg::CH_LO_OFF))) begin
                    ch_rlock_q[i] <= 1'b0;
                end
            end
        end
    end

    // buffered pair: the last written channel takes over at the wrap
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_wr_q <= 1'b0;
            buf_sel_q <= 1'b0;
        end else begin
            if (wr_at(ch_idx(0, mtc_pkg::CH_LO_OFF))) begin
                last_wr_q <= 1'b0;
            end else if (wr_at(ch_idx(1, mtc_pkg::CH_LO_OFF))) begin
                last_wr_q <= 1'b1;
            end
            if (!buffered) begin
                buf_sel_q <= 1'b0;
            end else if (wrap_evt) begin
                buf_sel_q <= last_wr_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // channel outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (srst) begin
                ch_out_q[i] <= 1'b1;
                ch_oe_q[i]  <= 1'b0;
                ch_irq_q[i] <= 1'b0;
            end else begin
                ch_irq_q[i] <= ch_sc_q[i][mtc_pkg::CH_FLAG] && ch_sc_q[i][mtc_pkg::CH_IE];
                ch_oe_q[i]  <= cmp_mode[i] && ch_sc_q[i][3:2] != mtc_pkg::MTC_ELS_OFF;
                if (ch_sc_q[i][3:2] == mtc_pkg::MTC_ELS_OFF) begin
                    ch_out_q[i] <= !ch_sc_q[i][mtc_pkg::CH_MSA];
                end else if (!cmp_mode[i]) begin
                    ch_out_q[i] <= ch_out_q[i];
                end else if (wrap_evt && ch_sc_q[i][mtc_pkg::CH_TOV]) begin
                    // overflow beats a coincident compare
                    if (ch_sc_q[i][mtc_pkg::CH_MAX]) begin
                        ch_out_q[i] <= ch_sc_q[i][3:2] == mtc_pkg::MTC_ELS_FALL;
                    end else begin
                        ch_out_q[i] <= !ch_out_q[i];
                    end
                end else if (cmp_evt[i] && !(ch_sc_q[i][mtc_pkg::CH_MAX] && ch_sc_q[i][mtc_pkg::CH_TOV])) begin
                    case (mtc_pkg::mtc_els_e'(ch_sc_q[i][3:2]))
                        mtc_pkg::MTC_ELS_RISE: ch_out_q[i] <= !ch_out_q[i];
                        mtc_pkg::MTC_ELS_FALL: ch_out_q[i] <= 1'b0;
                        mtc_pkg::MTC_ELS_BOTH: ch_out_q[i] <= 1'b1;
                        default:               ch_out_q[i] <= ch_out_q[i];
                    endcase
                end
            end
        end
    end

    assign chan0_pin_out = ch_out_q[0];
    assign chan1_pin_out = ch_out_q[1];
    assign chan0_pin_oe  = ch_oe_q[0];
    assign chan1_pin_oe  = ch_oe_q[1];
    assign chan0_irq     = ch_irq_q[0];
    assign chan1_irq     = ch_irq_q[1];

endmodule

//--- mtc_pkg.sv
// mtc_pkg: shared constants and types of the modulo timer core.
// assumes word-aligned AHB-Lite access; each byte register sits in
// the low byte of its own word.
package mtc_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS = 8'h40;
    localparam logic [7:0] IDX_CNT_HI = 8'h41;
    localparam logic [7:0] IDX_CNT_LO = 8'h42;
    localparam logic [7:0] IDX_PER_HI = 8'h43;
    localparam logic [7:0] IDX_PER_LO = 8'h44;
    localparam logic [7:0] IDX_CH0_SC = 8'h45;
    localparam logic [7:0] IDX_CH1_SC = 8'h48;
    localparam logic [7:0] CH_HI_OFF  = 8'h01;
    localparam logic [7:0] CH_LO_OFF  = 8'h02;
    localparam logic [7:0] IDX_NONE   = 8'hff;

    // ----------------------------------------------------------------
    // timer_status_control fields
    // ----------------------------------------------------------------
    localparam int unsigned SC_FLAG  = 7;
    localparam int unsigned SC_IE    = 6;
    localparam int unsigned SC_HALT  = 5;
    localparam int unsigned SC_RST   = 4;
    localparam logic [2:0]  SEL_EXT  = 3'h7;
    localparam logic [2:0]  SEL_RST  = 3'h0;

    // ----------------------------------------------------------------
    // channel status/control fields
    // ----------------------------------------------------------------
    localparam int unsigned CH_FLAG = 7;
    localparam int unsigned CH_IE   = 6;
    localparam int unsigned CH_MSB  = 5;
    localparam int unsigned CH_MSA  = 4;
    localparam int unsigned CH_TOV  = 1;
    localparam int unsigned CH_MAX  = 0;
    localparam logic [7:0]  CH_SC_RST = 8'h00;

    // ----------------------------------------------------------------
    // reset values and widths
    // ----------------------------------------------------------------
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [5:0]  PRESC_RST  = 6'h00;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam logic [21:0] HADDR_HI_0 = 22'h000000;

    // edge select in capture; in compare the same codes mean
    // toggle, clear and set
    typedef enum logic [1:0] {
        MTC_ELS_OFF  = 2'b00,
        MTC_ELS_RISE = 2'b01,
        MTC_ELS_FALL = 2'b10,
        MTC_ELS_BOTH = 2'b11
    } mtc_els_e;

endpackage

//--- mtc_pin_pad.sv
// mtc_pin_pad: the outside world on one timer channel pin.
// assumes the design's drive wins whenever its output enable is high.
`timescale 1ns/10ps
module mtc_pin_pad (
    input  wire logic drv_out,
    input  wire logic drv_oe,
    input  wire logic ext_lvl,
    output logic      pin_lvl
);
    assign pin_lvl = drv_oe ? drv_out : ext_lvl;
endmodule

//--- mtc_timer_props.sv
// mtc_timer_props: port-level assertions for the modulo timer core.
// assumes one clk_sys domain, srst synchronous, bound into mtc_timer.
`timescale 1ns/10ps
module mtc_timer_props (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        chan0_pin_oe,
    input wire logic        wrap_irq
);
    logic       rd_q, wr_q, ie_q, seen_q;
    logic [7:0] idx_q;
    wire        tk = hsel & hready & htrans[1] & (hsize == mtc_pkg::HSIZE_WORD);
    wire        ws = wr_q && (idx_q == mtc_pkg::IDX_STATUS);
    wire        rs = rd_q && (idx_q == mtc_pkg::IDX_STATUS);
    // enable mirror moves on the write data edge, the same edge the register takes it
    always_ff @(posedge clk_sys) begin
        rd_q   <= !srst && tk && !hwrite;
        wr_q   <= !srst && tk && hwrite;
        idx_q  <= tk ? haddr[9:2] : idx_q;
        ie_q   <= srst ? 1'h0 : (ws ? hwdata[mtc_pkg::SC_IE] : ie_q);
        seen_q <= !srst && (seen_q || ws);
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or not okay");
    chk_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("read upper bits set");
    chk_unmapped_zero: assert property (rd_q && (idx_q < 8'h40 || idx_q > 8'h4a) |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_reset: assert property (rs && !seen_q |-> hrdata[7:0] == 8'h20)
        else $error("status reset value wrong");
    chk_rst_reads_zero: assert property (rs |-> hrdata[4:3] == 2'h0) else $error("reset bit read");
    chk_irq_needs_en: assert property (wrap_irq |-> $past(ie_q)) else $error("irq without enable");
    chk_irq_holds: assert property (wrap_irq && !$past(ws) |=> wrap_irq) else $error("irq dropped");
    chk_reset_quiet: assert property ($past(srst) |-> !wrap_irq && !chan0_pin_oe)
        else $error("outputs active after reset");
endmodule
bind mtc_timer mtc_timer_props chk_u (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan0_pin_oe(chan0_pin_oe), .wrap_irq(wrap_irq));

//--- mtc_timer_tb.sv
// mtc_timer_tb: self-checking bench for the modulo timer core.
// assumes mtc_pkg, mtc_timer, mtc_pin_pad and the bound checker compile first.
`timescale 1ns/10ps
module mtc_timer_tb;
    logic        clk_sys = 1'h0, srst = 1'h1, hwrite = 1'h0, pin0 = 1'h0, rd_ph = 1'h0;
    logic        brk = 1'h0, ext_clk = 1'h0;
    logic        hrdy, hresp, p_in, p_out, p_oe, w_irq;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [15:0] exp_q [$], e;
    int          mismatches = 0, check_count = 0;
    // op: kind (0 read, 1 write, 2 pins ext/chan0, 3 test end, 5 break), index, data, idle in tens of cycles
    logic [23:0] ops_a [$] = {24'h040200, 24'h041000, 24'h042000, 24'h043ff0, 24'h044ff0,
        24'h050000, 24'h301000};
    logic [23:0] ops_b [$] = {24'h302000, 24'h140300, 24'h042000,
        24'h140162, 24'h04100a, 24'h041000, 24'h042000, 24'h042010, 24'h303000,
        24'h140300, 24'h143000, 24'h144040, 24'h140101, 24'h140200, 24'h042020, 24'h040a00,
        24'h140200, 24'h040200, 24'h140a00, 24'h040200,
        24'h140402, 24'h040c01, 24'h140600, 24'h040e00, 24'h304000,
        24'h145040, 24'h200011, 24'h045040, 24'h200000, 24'h140000, 24'h200011, 24'h045840,
        24'h305000,
        24'h1440f0, 24'h140100, 24'h500010, 24'h041000, 24'h500001, 24'h042000, 24'h0420c0, 24'h306000,
        24'h140170, 24'h200021, 24'h200001, 24'h200021, 24'h200001, 24'h042020, 24'h307000};
    mtc_timer dut_u (.clk_sys(clk_sys), .srst(srst), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(mtc_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .ext_count_clock_pin(ext_clk), .debug_break(brk),
        .chan0_pin_in(p_in), .chan0_pin_out(p_out), .chan0_pin_oe(p_oe), .chan1_pin_in(p_in),
        .chan1_pin_out(), .chan1_pin_oe(), .wrap_irq(w_irq), .chan0_irq(), .chan1_irq());
    mtc_pin_pad pad_u (.drv_out(p_out), .drv_oe(p_oe), .ext_lvl(pin0), .pin_lvl(p_in));
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // reads queue what the monitor must see in their data phase
    task automatic xf(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        if (!wr)
            exp_q.push_back({idx, d});
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'($urandom()), d};
        do @(posedge clk_sys); while (hrdy !== 1'h1);
    endtask
    task automatic run(input logic [23:0] op);
        case (op[23:20])
            4'h2: {ext_clk, pin0} <= op[5:4];
            4'h5: brk <= op[4];
            4'h3: $display("test %0d finished", op[19:12]);
            default: xf(op[20], op[19:12], op[11:4]);
        endcase
        repeat (10 * int'(op[3:0])) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (rd_ph) begin
            e = exp_q.pop_front();
            chk($sformatf("register %h", e[15:8]), hrdata, {24'h0, e[7:0]});
            // the irq output is registered like hrdata, so it matches the flag and enable that the status read returned
            if (e[15:8] == mtc_pkg::IDX_STATUS)
                chk("wrap irq", w_irq, e[7] & e[6]);
        end
        rd_ph <= htrans[1] & !hwrite & !srst;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // the plan needs about 1250 cycles; the margin keeps slow ticks from looking like a hang
    initial begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(52));
        repeat (5) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        foreach (ops_a[i])
            run(ops_a[i]);
        // counter reset starts 128 run edges, so each tap leaves 128 >> select counts
        for (int s = 0; s < 7; s++) begin
            xf(1'h1, 8'h40, 8'h10 | 8'(s));
            repeat (126) @(posedge clk_sys);
            xf(1'h1, 8'h40, 8'h20 | 8'(s));
            xf(1'h0, 8'h40, 8'h20 | 8'(s));
            xf(1'h0, 8'h42, 8'(128 >> s));
        end
        foreach (ops_b[i])
            run(ops_b[i]);
        repeat (4) @(posedge clk_sys);
        results();
    end
endmodule
